// >>> mgmt_pkg.sv
// shared constants and carrier types of the management register block
package mgmt_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ = 125_000_000;
  // longest time to full function after power-on or reset release
  localparam int unsigned INIT_TIME_MS = 2000;
  // least low time on the reset pin that counts as a module reset
  localparam int unsigned RESET_PULSE_US = 2;
  // longest time rounds down to whole cycles
  localparam int unsigned INIT_CYCLES = INIT_TIME_MS * (CLK_HZ / 1000);
  // least time rounds up to whole cycles
  localparam int unsigned RESET_PULSE_CYCLES =
    (RESET_PULSE_US * (CLK_HZ / 1000) + 999) / 1000;
  // 7-bit address on the 2-wire bus
  localparam logic [6:0] DEV_ADDR = 7'h50;
  // lower page byte offsets
  localparam logic [7:0] STATUS_OFS = 8'h02;
  localparam logic [7:0] FLAGS_OFS = 8'h05;
  localparam logic [7:0] PDOWN_OFS = 8'h5F;
  localparam logic [7:0] CDR_OFS = 8'h62;
  localparam logic [7:0] MASK_OFS = 8'h64;
  localparam logic [7:0] PAGE_OFS = 8'h7F;
  // upper page offsets, valid while page select holds UPPER_PAGE
  localparam logic [7:0] UPPER_PAGE = 8'h03;
  localparam logic [7:0] EQ_OFS = 8'hEA;
  localparam logic [7:0] EMPH_OFS = 8'hEC;
  localparam logic [7:0] AMP_OFS = 8'hEE;
  // field positions
  localparam int unsigned DNR_BIT = 0;
  localparam int unsigned PDOWN_BIT = 0;
  localparam int unsigned FLAG_TX_LSB = 4;
  localparam int unsigned FLAG_RX_LSB = 0;
  // reset values of host settings
  localparam logic [7:0] CDR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PDOWN_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] EQ_RST = 16'h0000;
  localparam logic [15:0] EMPH_RST = 16'h0000;
  localparam logic [15:0] AMP_RST = 16'h0000;
  // highest legal code of each 4-bit field
  localparam logic [3:0] EQ_MAX = 4'hA;
  localparam logic [3:0] EMPH_MAX = 4'h7;
  localparam logic [3:0] AMP_MAX = 4'h3;

  // kind of byte finished on the link
  typedef enum logic [1:0] {EV_PTR, EV_WDATA, EV_RDATA} ev_kind_t;

  // one finished byte handed from the link domain
  typedef struct packed {
    ev_kind_t kind;
    logic [7:0] data;
  } link_ev_t;
endpackage

// >>> bit_sync.sv
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/100ps
`default_nettype none

module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // destination clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // asynchronous levels in, settled levels out
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta; // first stage, read only by q_out

  // the first stage may go metastable; nothing but q_out looks at it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> cycle_timer.sv
// up-counter that flags when a run has lasted a given number of cycles
`timescale 1ns/100ps
`default_nettype none

module cycle_timer #(
  parameter int unsigned LIMIT = 1,
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // count while high, restart when low
  input wire logic run_in,
  output logic done_out
);
  logic [W-1:0] count; // cycles spent running

  // stops at the limit so it never wraps back to not-done
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
    end else if (!run_in) begin
      count <= '0;
    end else if (!done_out) begin
      count <= count + 1'b1;
    end
  end

  assign done_out = (count >= W'(LIMIT));
endmodule
`default_nettype wire

// >>> module_mgmt_status_control.sv
// management register bank with 2-wire link, lane flags and timers
`timescale 1ns/100ps
`default_nettype none

module module_mgmt_status_control #(
  // initialisation time in clocks; shorten for simulation
  parameter int unsigned INIT_CYCLES = mgmt_pkg::INIT_CYCLES,
  // address answered on the 2-wire bus
  parameter logic [6:0] DEV_ADDR = mgmt_pkg::DEV_ADDR
) (
  // system clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // 2-wire link, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // module pins, interrupt open drain
  input wire logic module_select_n_in,
  input wire logic module_reset_n_in,
  input wire logic low_power_request_in,
  output logic interrupt_n_out,
  output logic interrupt_n_oe_out,
  // lane lock-loss levels, bit 3 is lane 4
  input wire logic [3:0] tx_lock_lost_in,
  input wire logic [3:0] rx_lock_lost_in,
  // lane controls, bit 3 is lane 4
  output logic [3:0] tx_recovery_on_out,
  output logic [3:0] rx_recovery_on_out,
  // 4-bit codes, nibble 15:12 is lane 1
  output logic [15:0] tx_eq_out,
  output logic [15:0] rx_emph_out,
  output logic [15:0] rx_amp_out,
  // power and readiness
  output logic low_power_out,
  output logic module_ready_out
);
  // register selected by a pointer and page
  typedef enum logic [3:0] {
    SEL_NONE, SEL_STATUS, SEL_FLAGS, SEL_PDOWN, SEL_CDR, SEL_MASK,
    SEL_PAGE, SEL_EQ_HI, SEL_EQ_LO, SEL_EM_HI, SEL_EM_LO,
    SEL_AMP_HI, SEL_AMP_LO
  } sel_t;

  // which code table applies to a field
  typedef enum logic [1:0] {FIELD_EQ, FIELD_EMPH, FIELD_AMP} field_t;

  // address decode, shared by reads and writes
  function automatic sel_t reg_sel(input logic [7:0] a,
                                   input logic [7:0] pg);
    reg_sel = SEL_NONE;
    if (a == mgmt_pkg::STATUS_OFS) reg_sel = SEL_STATUS;
    else if (a == mgmt_pkg::FLAGS_OFS) reg_sel = SEL_FLAGS;
    else if (a == mgmt_pkg::PDOWN_OFS) reg_sel = SEL_PDOWN;
    else if (a == mgmt_pkg::CDR_OFS) reg_sel = SEL_CDR;
    else if (a == mgmt_pkg::MASK_OFS) reg_sel = SEL_MASK;
    else if (a == mgmt_pkg::PAGE_OFS) reg_sel = SEL_PAGE;
    else if (pg == mgmt_pkg::UPPER_PAGE) begin
      if (a == mgmt_pkg::EQ_OFS) reg_sel = SEL_EQ_HI;
      else if (a == mgmt_pkg::EQ_OFS + 8'h01) reg_sel = SEL_EQ_LO;
      else if (a == mgmt_pkg::EMPH_OFS) reg_sel = SEL_EM_HI;
      else if (a == mgmt_pkg::EMPH_OFS + 8'h01) reg_sel = SEL_EM_LO;
      else if (a == mgmt_pkg::AMP_OFS) reg_sel = SEL_AMP_HI;
      else if (a == mgmt_pkg::AMP_OFS + 8'h01) reg_sel = SEL_AMP_LO;
    end
  endfunction

  // legal code check per field
  function automatic logic code_ok(input field_t f, input logic [3:0] c);
    unique case (f)
      FIELD_EQ: code_ok = (c <= mgmt_pkg::EQ_MAX);
      FIELD_EMPH: code_ok = (c <= mgmt_pkg::EMPH_MAX);
      FIELD_AMP: code_ok = (c <= mgmt_pkg::AMP_MAX);
      default: code_ok = 1'b0;
    endcase
  endfunction

  // reserved codes leave the nibble as it was
  function automatic logic [7:0] merge_codes(input field_t f,
                                             input logic [7:0] old_v,
                                             input logic [7:0] new_v);
    merge_codes[7:4] = code_ok(f, new_v[7:4]) ? new_v[7:4] : old_v[7:4];
    merge_codes[3:0] = code_ok(f, new_v[3:0]) ? new_v[3:0] : old_v[3:0];
  endfunction

  // ---- link domain (scl_in) ----
  logic frame_clr; // start or stop seen, from mclk domain
  logic link_rst_n; // clears frame state at each start or stop
  logic bus_en; // answering allowed, mclk domain
  logic bus_en_link; // same, settled on the link clock
  logic [3:0] bit_cnt; // 0-7 data bits, 8 acknowledge slot
  logic [7:0] rx_sh; // bits shifted in, msb first
  logic [7:0] rx_full; // byte including the bit on the wire now
  logic first_byte; // address byte still in progress
  logic addressed; // our address was acknowledged
  logic reading; // direction bit of the address byte
  logic master_nack; // host ended the read
  logic ptr_done; // pointer byte already taken
  logic addr_hit; // address byte matches ours
  logic ev_take; // a data byte completes on this edge
  logic ack_drive; // pulling data low for acknowledge
  logic rd_drive; // driving read data
  logic [7:0] tx_sh; // read byte being shifted out
  logic [7:0] tx_hold; // copy of the byte loaded for reading
  logic ev_tog; // flips once per finished data byte
  mgmt_pkg::link_ev_t ev; // finished byte, stable until next flip

  // ---- system domain (mclk_in) ----
  logic [12:0] pins_raw; // pins bundled for one synchroniser
  logic [12:0] pins_s; // settled pins
  logic scl_s, sda_s, sel_n_s, rpin_s, lp_s;
  logic [3:0] tx_ll_s, rx_ll_s; // settled lock-loss levels
  logic scl_d, sda_d; // previous settled bus levels
  logic ev_tog_s; // settled event toggle
  logic ev_seen; // last toggle value handled
  logic ev_fire; // one-cycle pulse per finished byte
  sel_t ev_sel; // register under the pointer
  logic is_wr, is_rd; // write or read byte finished
  logic rst_long; // reset pin low long enough
  logic mod_rst; // module reset in force
  logic init_done; // initialisation time elapsed
  logic dnr; // data not ready
  logic init_int; // ready event awaiting a status read
  logic [7:0] ptr; // byte pointer
  logic [7:0] page; // upper page select
  logic [7:0] flags; // latched lock-loss flags
  logic [7:0] flag_set; // lanes losing lock now
  logic [7:0] flag_clr; // bits just read out
  logic [7:0] mask; // interrupt mask for the flags
  logic [7:0] cdr; // recovery on/off per lane
  logic [7:0] pdown; // power-down override
  logic [15:0] eq, emph, amp; // lane code fields
  logic [7:0] tx_byte; // byte the link sends on the next read

  // start/stop clears the link frame logic asynchronously; the pulse
  // ends long before the next scl rise, so release is safe
  assign link_rst_n = rst_n_in & ~frame_clr;
  assign rx_full = {rx_sh[6:0], sda_in};
  assign addr_hit = (rx_sh[7:1] == DEV_ADDR);
  assign ev_take = (bit_cnt == 4'h7) & ~first_byte & addressed &
                   ~master_nack;

  // answer gate crosses into the link domain as a level
  bit_sync #(.W(1), .RST_VAL(1'b0)) u_en_sync (
    .clk_in(scl_in),
    .rst_n_in(rst_n_in),
    .d_in(bus_en),
    .q_out(bus_en_link)
  );

  // bit counting and frame state on rising scl
  always_ff @(posedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= 4'h0;
      rx_sh <= 8'h00;
      first_byte <= 1'b1;
      addressed <= 1'b0;
      reading <= 1'b0;
      master_nack <= 1'b0;
      ptr_done <= 1'b0;
    end else begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt != 4'h8) begin
        rx_sh <= rx_full;
      end
      if (bit_cnt == 4'h8) begin
        first_byte <= 1'b0;
        if (first_byte) begin
          // only a selected module takes the frame
          addressed <= addr_hit & bus_en_link;
          reading <= rx_sh[0];
        end else if (reading & sda_in) begin
          master_nack <= 1'b1;
        end
      end
      if (ev_take & ~reading) begin
        ptr_done <= 1'b1;
      end
    end
  end

  // byte hand-over; kept out of the frame reset so no flip is lost
  always_ff @(posedge scl_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_tog <= 1'b0;
      ev <= '0;
    end else if (ev_take) begin
      ev_tog <= ~ev_tog;
      ev.data <= reading ? tx_hold : rx_full;
      if (reading) begin
        ev.kind <= mgmt_pkg::EV_RDATA;
      end else if (ptr_done) begin
        ev.kind <= mgmt_pkg::EV_WDATA;
      end else begin
        ev.kind <= mgmt_pkg::EV_PTR;
      end
    end
  end

  // data line driving on falling scl; tx_byte is quiet for a whole
  // bit time before it is loaded here
  always_ff @(negedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      ack_drive <= 1'b0;
      rd_drive <= 1'b0;
      tx_sh <= 8'hFF;
      tx_hold <= 8'h00;
    end else begin
      ack_drive <= (bit_cnt == 4'h8) & bus_en_link &
                   (first_byte ? addr_hit : addressed & ~reading);
      if (bit_cnt == 4'h0) begin
        tx_sh <= tx_byte;
        tx_hold <= tx_byte;
        rd_drive <= addressed & reading & ~master_nack & bus_en_link;
      end else if (bit_cnt == 4'h8) begin
        rd_drive <= 1'b0;
      end else begin
        tx_sh <= {tx_sh[6:0], 1'b1};
      end
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe_out = ack_drive | (rd_drive & ~tx_sh[7]);

  // ---- system domain logic ----
  assign pins_raw = {scl_in, sda_in, module_select_n_in, module_reset_n_in,
                     low_power_request_in, tx_lock_lost_in, rx_lock_lost_in};

  // every pin passes two flops before use on mclk; the link logic samples scl_in and sda_in directly
  bit_sync #(.W(13), .RST_VAL(13'h1E00)) u_pin_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in(pins_raw),
    .q_out(pins_s)
  );

  assign {scl_s, sda_s, sel_n_s, rpin_s, lp_s, tx_ll_s, rx_ll_s} = pins_s;

  // event toggle from the link domain
  bit_sync #(.W(1), .RST_VAL(1'b0)) u_ev_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .d_in(ev_tog),
    .q_out(ev_tog_s)
  );

  // start/stop: data changes while the clock is high
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      frame_clr <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      frame_clr <= scl_s & scl_d & (sda_d ^ sda_s);
    end
  end

  // reset pin must stay low for the minimum pulse
  cycle_timer #(.LIMIT(mgmt_pkg::RESET_PULSE_CYCLES), .W(9)) u_rst_filt (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .run_in(~rpin_s),
    .done_out(rst_long)
  );

  // module reset holds from a long pulse until the pin rises
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mod_rst <= 1'b0;
    end else if (rst_long) begin
      mod_rst <= 1'b1;
    end else if (rpin_s) begin
      mod_rst <= 1'b0;
    end
  end

  // initialisation runs after power-on and after reset release
  cycle_timer #(.LIMIT(INIT_CYCLES), .W(32)) u_init (
    .clk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .run_in(dnr & ~mod_rst),
    .done_out(init_done)
  );

  // no answers during a module reset or while deselected
  assign bus_en = ~sel_n_s & ~mod_rst;

  // handle each finished byte once
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_seen <= 1'b0;
    end else begin
      ev_seen <= ev_tog_s;
    end
  end

  assign ev_fire = ev_tog_s ^ ev_seen;
  assign ev_sel = reg_sel(ptr, page);
  assign is_wr = ev_fire & (ev.kind == mgmt_pkg::EV_WDATA);
  assign is_rd = ev_fire & (ev.kind == mgmt_pkg::EV_RDATA);

  // readiness: not-ready drops and the ready interrupt rises together;
  // a new ready event beats a status read in the same cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dnr <= 1'b1;
      init_int <= 1'b0;
    end else if (mod_rst) begin
      dnr <= 1'b1;
      init_int <= 1'b0;
    end else if (init_done & dnr) begin
      dnr <= 1'b0;
      init_int <= 1'b1;
    end else if (is_rd & (ev_sel == SEL_STATUS)) begin
      init_int <= 1'b0;
    end
  end

  // byte pointer: set by the first written byte, then auto-increments
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr <= 8'h00;
    end else if (mod_rst) begin
      ptr <= 8'h00;
    end else if (ev_fire) begin
      if (ev.kind == mgmt_pkg::EV_PTR) begin
        ptr <= ev.data;
      end else begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  // host settings; a module reset puts them all back
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cdr <= mgmt_pkg::CDR_RST;
      mask <= mgmt_pkg::MASK_RST;
      pdown <= mgmt_pkg::PDOWN_RST;
      page <= mgmt_pkg::PAGE_RST;
      eq <= mgmt_pkg::EQ_RST;
      emph <= mgmt_pkg::EMPH_RST;
      amp <= mgmt_pkg::AMP_RST;
    end else if (mod_rst) begin
      cdr <= mgmt_pkg::CDR_RST;
      mask <= mgmt_pkg::MASK_RST;
      pdown <= mgmt_pkg::PDOWN_RST;
      page <= mgmt_pkg::PAGE_RST;
      eq <= mgmt_pkg::EQ_RST;
      emph <= mgmt_pkg::EMPH_RST;
      amp <= mgmt_pkg::AMP_RST;
    end else if (is_wr) begin
      unique case (ev_sel)
        SEL_CDR: cdr <= ev.data;
        SEL_MASK: mask <= ev.data;
        SEL_PDOWN: pdown <= ev.data;
        SEL_PAGE: page <= ev.data;
        SEL_EQ_HI: eq[15:8] <= merge_codes(FIELD_EQ, eq[15:8], ev.data);
        SEL_EQ_LO: eq[7:0] <= merge_codes(FIELD_EQ, eq[7:0], ev.data);
        SEL_EM_HI: emph[15:8] <= merge_codes(FIELD_EMPH, emph[15:8], ev.data);
        SEL_EM_LO: emph[7:0] <= merge_codes(FIELD_EMPH, emph[7:0], ev.data);
        SEL_AMP_HI: amp[15:8] <= merge_codes(FIELD_AMP, amp[15:8], ev.data);
        SEL_AMP_LO: amp[7:0] <= merge_codes(FIELD_AMP, amp[7:0], ev.data);
        // read-only and unmapped bytes ignore writes
        default: ;
      endcase
    end
  end

  // lock-loss set terms per lane
  always_comb begin
    flag_set = 8'h00;
    flag_set[mgmt_pkg::FLAG_TX_LSB +: 4] = tx_ll_s;
    flag_set[mgmt_pkg::FLAG_RX_LSB +: 4] = rx_ll_s;
  end

  // only the bits actually shifted out are cleared
  assign flag_clr = (is_rd & (ev_sel == SEL_FLAGS)) ? ev.data : 8'h00;

  // latched flags: set wins over clear-on-read, held while lock returns
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags <= 8'h00;
    end else if (mod_rst) begin
      flags <= 8'h00;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
    end
  end

  // byte offered for the next read, refreshed every cycle
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_byte <= 8'h00;
    end else begin
      unique case (ev_sel)
        SEL_STATUS: tx_byte <= {7'h00, dnr} << mgmt_pkg::DNR_BIT;
        SEL_FLAGS: tx_byte <= flags;
        SEL_PDOWN: tx_byte <= pdown;
        SEL_CDR: tx_byte <= cdr;
        SEL_MASK: tx_byte <= mask;
        SEL_PAGE: tx_byte <= page;
        SEL_EQ_HI: tx_byte <= eq[15:8];
        SEL_EQ_LO: tx_byte <= eq[7:0];
        SEL_EM_HI: tx_byte <= emph[15:8];
        SEL_EM_LO: tx_byte <= emph[7:0];
        SEL_AMP_HI: tx_byte <= amp[15:8];
        SEL_AMP_LO: tx_byte <= amp[7:0];
        // unmapped bytes read as zero
        default: tx_byte <= 8'h00;
      endcase
    end
  end

  // interrupt and power outputs; a cycle each, far inside the limits
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      interrupt_n_oe_out <= 1'b0;
      low_power_out <= 1'b0;
    end else begin
      interrupt_n_oe_out <= (|(flags & ~mask)) | init_int;
      low_power_out <= lp_s | pdown[mgmt_pkg::PDOWN_BIT];
    end
  end

  // lane controls straight from their registers
  assign interrupt_n_out = 1'b0;
  assign tx_recovery_on_out = cdr[7:4];
  assign rx_recovery_on_out = cdr[3:0];
  assign tx_eq_out = eq;
  assign rx_emph_out = emph;
  assign rx_amp_out = amp;
  assign module_ready_out = ~dnr;
endmodule
`default_nettype wire

// >>> mgmt_asserts.sv
// port timing checker for the management register block
`timescale 1ns/100ps
`default_nettype none
module mgmt_asserts #(
  parameter int unsigned INIT_CYCLES = 200
) (
  // clock, reset and module pins
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic module_select_n_in,
  input wire logic module_reset_n_in,
  input wire logic low_power_request_in,
  // watched outputs
  input wire logic sda_oe_out,
  input wire logic interrupt_n_oe_out,
  input wire logic low_power_out,
  input wire logic module_ready_out,
  input wire logic [3:0] tx_recovery_on_out,
  input wire logic [15:0] tx_eq_out,
  input wire logic [15:0] rx_emph_out,
  input wire logic [15:0] rx_amp_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  int unsigned up; // cycles since release, saturates so it fires once
  logic [8:0] low_run; // cycles the reset pin has stayed low
  // time since power-on reset release
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) up <= 0;
    else if (up < INIT_CYCLES + 100) up <= up + 1;
  end
  // length of the current low run on the reset pin
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) low_run <= 9'h000;
    else if (module_reset_n_in) low_run <= 9'h000;
    else if (low_run != 9'h1FF) low_run <= low_run + 9'h001;
  end
  // every nibble at or below its top legal code
  function automatic logic codes_ok(logic [15:0] v, logic [3:0] top);
    return v[15:12] <= top && v[11:8] <= top && v[7:4] <= top &&
      v[3:0] <= top;
  endfunction
  sequence lp_held; low_power_request_in [*6]; endsequence
  sequence deselected; module_select_n_in [*8]; endsequence
  ready_irq_a: assert property ($rose(module_ready_out) |=>
    interrupt_n_oe_out) else $error("ready without interrupt");
  init_early_a: assert property (module_ready_out |->
    up >= INIT_CYCLES) else $error("ready too early");
  init_late_a: assert property (up == INIT_CYCLES + 8 |->
    module_ready_out) else $error("ready too late");
  module_reset_a: assert property (low_run > 9'h104 |->
    !module_ready_out && tx_recovery_on_out == 4'h0 && tx_eq_out == 16'h0000)
    else $error("module reset not taken");
  low_power_a: assert property (lp_held |-> low_power_out)
    else $error("low power late");
  deselect_quiet_a: assert property (deselected |-> !sda_oe_out)
    else $error("answer while deselected");
  eq_codes_a: assert property (codes_ok(tx_eq_out, 4'hA))
    else $error("reserved equalization code");
  emph_codes_a: assert property (codes_ok(rx_emph_out, 4'h7))
    else $error("reserved emphasis code");
  amp_codes_a: assert property (codes_ok(rx_amp_out, 4'h3))
    else $error("reserved amplitude code");
endmodule
bind module_mgmt_status_control mgmt_asserts #(.INIT_CYCLES(INIT_CYCLES))
  chk_i (.mclk_in, .rst_n_in, .module_select_n_in, .module_reset_n_in,
  .low_power_request_in, .sda_oe_out, .interrupt_n_oe_out, .low_power_out,
  .module_ready_out, .tx_recovery_on_out, .tx_eq_out, .rx_emph_out,
  .rx_amp_out);
`default_nettype wire

// >>> host_2wire_model.sv
// host side of the 2-wire bus; scl rests high between frames
`timescale 1ns/100ps
`default_nettype none
module host_2wire_model (
  // bus clock and data pull-down
  output logic scl_out,
  output logic oe_out,
  // level seen on the data wire
  input wire logic sda_in
);
  initial begin
    scl_out = 1'b1;
    oe_out = 1'b0;
  end
  // one 80 ns bit; data moves 20 ns after the fall, never with scl high
  // edges sit 2 ns off the system clock rise so its synchroniser never
  // races a bus edge
  task automatic bit_slot(input logic pull, output logic s);
    #18 oe_out = pull;
    #20 scl_out = 1'b1;
    #20 s = sda_in;
    #20 scl_out = 1'b0;
    #2;
  endtask
  // start or repeated start: data falls while scl is high
  task automatic start();
    #18 oe_out = 1'b0;
    #20 scl_out = 1'b1;
    #20 oe_out = 1'b1;
    #20 scl_out = 1'b0;
    #2;
  endtask
  task automatic stop();
    #18 oe_out = 1'b1;
    #20 scl_out = 1'b1;
    #20 oe_out = 1'b0;
    #22;
  endtask
  // byte out, msb first, then the device's ack slot
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(!b[i], s);
    bit_slot(1'b0, s);
    ack = !s;
  endtask
  // byte in, closed by a nack so the device lets go
  task automatic get(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b0, s);
      d[i] = s;
    end
    bit_slot(1'b0, s);
  endtask
endmodule
`default_nettype wire

// >>> module_mgmt_status_control_bench.sv
// self-checking bench for the management register block
`timescale 1ns/100ps
`default_nettype none
module module_mgmt_status_control_bench;
  // pins driven by the bench
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic module_select_n_in = 1'b0;
  logic module_reset_n_in = 1'b1;
  logic low_power_request_in = 1'b0;
  logic [3:0] tx_lock_lost_in = 4'h0;
  logic [3:0] rx_lock_lost_in = 4'h0;
  // bus wires; data has a pull-up
  logic scl_in, host_oe, sda_oe_out;
  wire sda_in = !(sda_oe_out | host_oe);
  // design outputs
  logic interrupt_n_oe_out, low_power_out, module_ready_out;
  logic [3:0] tx_recovery_on_out, rx_recovery_on_out;
  logic [15:0] tx_eq_out, rx_emph_out, rx_amp_out;
  int fails = 0;
  int checks_done = 0;
  logic ok;
  logic [7:0] d;
  always #4 mclk_in = !mclk_in;
  module_mgmt_status_control #(.INIT_CYCLES(200)) dut (.mclk_in, .rst_n_in,
    .scl_in, .sda_in, .sda_out(), .sda_oe_out, .module_select_n_in,
    .module_reset_n_in, .low_power_request_in, .interrupt_n_out(),
    .interrupt_n_oe_out, .tx_lock_lost_in, .rx_lock_lost_in,
    .tx_recovery_on_out, .rx_recovery_on_out, .tx_eq_out, .rx_emph_out,
    .rx_amp_out, .low_power_out, .module_ready_out);
  host_2wire_model host (.scl_out(scl_in), .oe_out(host_oe), .sda_in);
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks_done++;
    if (got !== want) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // write from offset a; ok holds the address ack
  task automatic wr(input logic [7:0] a, input logic [7:0] q[$]);
    logic k;
    host.start();
    host.put(8'hA0, ok);
    host.put(a, k);
    foreach (q[i]) host.put(q[i], k);
    host.stop();
    tick(2);
  endtask
  task automatic rd(input logic [7:0] a);
    logic k;
    host.start();
    host.put(8'hA0, k);
    host.put(a, k);
    host.start();
    host.put(8'hA1, k);
    host.get(d);
    host.stop();
    tick(2);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 400 && module_ready_out !== 1'b1; i++) tick(1);
    tick(2);
  endtask
  task automatic t_ready();
    wait_ready();
    chk(interrupt_n_oe_out, 1'b1);
    rd(8'h02);
    chk(d[0], 1'b0);
    chk(interrupt_n_oe_out, 1'b0);
  endtask
  task automatic t_cdr();
    wr(8'h62, '{8'hA5});
    chk(ok, 1'b1);
    chk({tx_recovery_on_out, rx_recovery_on_out}, 8'hA5);
    rd(8'h62);
    chk(d, 8'hA5);
  endtask
  // reserved nibbles keep their old value, legal ones land
  task automatic t_codes();
    wr(8'h7F, '{8'h03});
    wr(8'hEA, '{8'h1C, 8'hB7, 8'h78, 8'h39, 8'h34, 8'h23});
    chk(tx_eq_out, 16'h1007);
    chk(rx_emph_out, 16'h7030);
    chk(rx_amp_out, 16'h3023);
  endtask
  // lock lost briefly; the latch must outlast it
  task automatic t_flags(input logic [7:0] mask);
    wr(8'h64, '{mask});
    {tx_lock_lost_in, rx_lock_lost_in} <= 8'h81;
    tick(10);
    {tx_lock_lost_in, rx_lock_lost_in} <= 8'h00;
    tick(6);
    chk(interrupt_n_oe_out, mask == 8'h00);
    rd(8'h05);
    chk(d, 8'h81);
    chk(interrupt_n_oe_out, 1'b0);
    rd(8'h05);
    chk(d, 8'h00);
  endtask
  task automatic t_select();
    module_select_n_in <= 1'b1;
    tick(4);
    wr(8'h62, '{8'h00});
    chk(ok, 1'b0);
    chk(tx_recovery_on_out, 4'hA);
    module_select_n_in <= 1'b0;
    tick(4);
  endtask
  task automatic t_power();
    low_power_request_in <= 1'b1;
    tick(6);
    chk(low_power_out, 1'b1);
    low_power_request_in <= 1'b0;
    tick(6);
    wr(8'h5F, '{8'h01});
    chk(low_power_out, 1'b1);
    wr(8'h5F, '{8'h00});
    chk(low_power_out, 1'b0);
  endtask
  // a short pulse is ignored, a long one restores defaults
  task automatic t_modrst();
    module_reset_n_in <= 1'b0;
    tick(200);
    module_reset_n_in <= 1'b1;
    tick(4);
    chk(module_ready_out, 1'b1);
    module_reset_n_in <= 1'b0;
    tick(270);
    chk(module_ready_out, 1'b0);
    chk(tx_eq_out, 16'h0000);
    module_reset_n_in <= 1'b1;
    wait_ready();
    chk(module_ready_out, 1'b1);
    chk(tx_recovery_on_out, 4'h0);
  endtask
  initial begin
    tick(4);
    rst_n_in <= 1'b1;
    t_ready();
    t_cdr();
    t_codes();
    t_flags(8'h00);
    t_flags(8'hFF);
    t_select();
    t_power();
    t_modrst();
    tally_and_finish();
  end
  // watchdog well beyond the expected run of about 50 us
  initial begin
    #500000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
